// ==== verilog/vsdc_pkg.sv ====
// Purpose: shared constants and types for the valley switching control core
// Assumes: 10 MHz system clock
// Notes: times are given in their own unit and converted to cycles here
package vsdc_pkg;
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned SS_TIME_MS = 12;
   localparam int unsigned SS_STEPS = 4;
   localparam int unsigned SS_STEP_CYC = (CLK_HZ / 1000) * SS_TIME_MS / SS_STEPS;
   localparam int unsigned EVAL_TIME_MS = 48;
   localparam int unsigned EVAL_CYC = (CLK_HZ / 1000) * EVAL_TIME_MS;
   localparam int unsigned RING_TIME_US = 3;
   localparam int unsigned RING_CYC = (CLK_HZ / 1000000) * RING_TIME_US;
   localparam int unsigned OFFMAX_TIME_US = 50;
   localparam int unsigned OFFMAX_CYC = (CLK_HZ / 1000000) * OFFMAX_TIME_US;
   localparam int unsigned OVP_BLANK_US = 2;
   localparam int unsigned OVP_BLANK_CYC = (CLK_HZ / 1000000) * OVP_BLANK_US;
   localparam logic [2:0] UDC_MIN = 3'h1;
   localparam logic [2:0] UDC_MAX = 3'h7;
   localparam logic [2:0] UDC_RESET = 3'h1;
   localparam logic [2:0] VC_MAX = 3'h7;
   localparam logic [2:0] VC_RESET = 3'h0;
   localparam logic [1:0] SS_STEP_LAST = 2'h3;
   localparam logic [2:0] CS_LIMIT_FULL = 3'h4;

   // comparator inputs from the analog front end, all asynchronous
   typedef struct packed {
      logic fb_above_low;
      logic fb_above_high;
      logic fb_above_reset;
      logic valley_below_cross;
      logic valley_above_ovp;
      logic cs_trip;
      logic supply_above_on;
   } vsdc_cmp_t;

   typedef enum logic [3:0] {
      ST_STARTUP = 4'h1,
      ST_ON = 4'h2,
      ST_RING = 4'h4,
      ST_WAIT = 4'h8
   } vsdc_state_t;
endpackage

// ==== verilog/vsdc_sync.sv ====
// Purpose: two flip-flop synchroniser for a bus of comparator levels
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module vsdc_sync #(
   parameter int WIDTH = 7
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // data
   input wire logic [WIDTH-1:0] d_async,
   output logic [WIDTH-1:0] q_sync
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q_sync <= '0;
      end else begin
         meta_reg <= d_async;
         q_sync <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/vsdc_core.sv ====
// Purpose: digital switch-on control of a quasi-resonant flyback controller
// Assumes: analog comparators and switch-off path outside; 10 MHz clock
// Notes: ringing, off-time and overvoltage blanking times are plain defaults
// Overview of operation
// - supply above threshold: stop charger, soft start
// - soft start: 12 ms in four steps
// - current limit steps up to full value
// - counters turn on, analog comparator turns off
// - evaluate feedback every 48 ms
// - always below low: count up to 7
// - above low, below high: hold
// - above high, below reset: count down to 1
// - above reset: force counter to 1
// - counter stays within 1 to 7
// - counter starts at 1
// - thresholds selected by line level
// - valley counter ranges 0 to 7
// - falling crossing after turn-off counts valley
// - valley counter cleared on gate rising
// - overvoltage while off latches off after blanking
// - after ringing, turn on when valleys reach target
// - no turn on during ringing suppression
// - maximum off time forces turn on
`timescale 1ns/1ps
`default_nettype none
module vsdc_core
   import vsdc_pkg::*;
#(
   parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC,
   parameter int unsigned EVAL_CYCLES = EVAL_CYC,
   parameter int unsigned OFFMAX_CYCLES = OFFMAX_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // comparator levels from the analog front end
   input wire vsdc_cmp_t cmp_async,
   input wire logic line_high_async,
   // start-up cell and analog front end control
   output logic startup_cell_en,
   output logic [2:0] cs_limit_step,
   output logic fb_thresh_high_line,
   // gate request and status
   output logic gate_on,
   output logic latched_off,
   output logic [2:0] udc_value,
   output logic [2:0] valley_count
);
   localparam int CW = 24;
   localparam logic [CW-1:0] SS_END = CW'(SS_STEP_CYCLES - 1);
   localparam logic [CW-1:0] EVAL_END = CW'(EVAL_CYCLES - 1);
   localparam logic [CW-1:0] OFFMAX_END = CW'(OFFMAX_CYCLES - 1);
   localparam logic [CW-1:0] RING_END = CW'(RING_CYC - 1);
   localparam logic [CW-1:0] OVP_END = CW'(OVP_BLANK_CYC - 1);

   vsdc_cmp_t cmp;
   logic line_high;
   vsdc_state_t state_reg;
   logic running_reg;
   logic [1:0] ss_step_reg;
   logic ss_done_reg;
   logic [CW-1:0] ss_cnt_reg;
   logic [CW-1:0] eval_cnt_reg;
   logic eval_tick;
   logic seen_low_reg, seen_high_reg, seen_reset_reg;
   logic [CW-1:0] off_cnt_reg;
   logic [CW-1:0] ovp_cnt_reg;
   logic cross_prev_reg;
   logic cross_fall;
   logic gate_prev_reg;
   logic gate_rise;
   logic turn_on;

   vsdc_sync #(.WIDTH(8)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d_async({cmp_async, line_high_async}),
      .q_sync({cmp, line_high})
   );

   // start-up: charger on until supply crosses turn-on, then run
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         running_reg <= 1'b0;
      end else if (cmp.supply_above_on && !latched_off) begin
         running_reg <= 1'b1;
      end
   end
   assign startup_cell_en = !running_reg;

   // soft start timer: four equal steps of the current-sense limit
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ss_cnt_reg <= '0;
         ss_step_reg <= '0;
         ss_done_reg <= 1'b0;
      end else if (running_reg && !ss_done_reg) begin
         if (ss_cnt_reg == SS_END) begin
            ss_cnt_reg <= '0;
            if (ss_step_reg == SS_STEP_LAST) begin
               ss_done_reg <= 1'b1;
            end else begin
               ss_step_reg <= ss_step_reg + 2'h1;
            end
         end else begin
            ss_cnt_reg <= ss_cnt_reg + 1'b1;
         end
      end
   end
   // step 0 is the lowest limit, full value once soft start ends
   assign cs_limit_step = ss_done_reg ? CS_LIMIT_FULL : {1'b0, ss_step_reg};

   // line level picks the feedback threshold pair in the analog block
   assign fb_thresh_high_line = line_high;

   // evaluation period timer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         eval_cnt_reg <= '0;
      end else if (!running_reg || eval_tick) begin
         eval_cnt_reg <= '0;
      end else begin
         eval_cnt_reg <= eval_cnt_reg + 1'b1;
      end
   end
   assign eval_tick = running_reg && (eval_cnt_reg == EVAL_END);

   // sticky crossings; a crossing in the closing cycle counts in this period
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seen_low_reg <= 1'b0;
         seen_high_reg <= 1'b0;
         seen_reset_reg <= 1'b0;
      end else if (eval_tick) begin
         seen_low_reg <= 1'b0;
         seen_high_reg <= 1'b0;
         seen_reset_reg <= 1'b0;
      end else begin
         seen_low_reg <= seen_low_reg | cmp.fb_above_low;
         seen_high_reg <= seen_high_reg | cmp.fb_above_high;
         seen_reset_reg <= seen_reset_reg | cmp.fb_above_reset;
      end
   end

   // up/down counter, decided at the period end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         udc_value <= UDC_RESET;
      end else if (!running_reg) begin
         udc_value <= UDC_RESET;
      end else if (eval_tick) begin
         if (seen_reset_reg || cmp.fb_above_reset) begin
            udc_value <= UDC_RESET;
         end else if (seen_high_reg || cmp.fb_above_high) begin
            if (udc_value != UDC_MIN) begin
               udc_value <= udc_value - 3'h1;
            end
         end else if (seen_low_reg || cmp.fb_above_low) begin
            udc_value <= udc_value;
         end else if (udc_value != UDC_MAX) begin
            udc_value <= udc_value + 3'h1;
         end
      end
   end

   // valley crossing edge detect on the synchronised level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cross_prev_reg <= 1'b0;
         gate_prev_reg <= 1'b0;
      end else begin
         cross_prev_reg <= cmp.valley_below_cross;
         gate_prev_reg <= gate_on;
      end
   end
   assign cross_fall = cmp.valley_below_cross && !cross_prev_reg;
   assign gate_rise = gate_on && !gate_prev_reg;

   // valley counter: clear on gate rising, count crossings while off
   // only after a turn-off: the idle pin sits below the level, so its first rise after reset is no valley
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         valley_count <= VC_RESET;
      end else if (gate_rise) begin
         valley_count <= VC_RESET;
      end else if ((state_reg == ST_RING || state_reg == ST_WAIT) && cross_fall
                   && valley_count != VC_MAX) begin
         valley_count <= valley_count + 3'h1;
      end
   end

   // overvoltage blanking, then permanent latch-off
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ovp_cnt_reg <= '0;
         latched_off <= 1'b0;
      end else if (running_reg && !gate_on && cmp.valley_above_ovp) begin
         if (ovp_cnt_reg == OVP_END) begin
            latched_off <= 1'b1;
         end else begin
            ovp_cnt_reg <= ovp_cnt_reg + 1'b1;
         end
      end else begin
         ovp_cnt_reg <= '0;
      end
   end

   // switch-on decision; switch-off comes from the current-sense comparator
   assign turn_on = (valley_count >= udc_value) || (off_cnt_reg == OFFMAX_END);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_STARTUP;
         off_cnt_reg <= '0;
      end else if (latched_off) begin
         state_reg <= ST_STARTUP;
         off_cnt_reg <= '0;
      end else begin
         case (state_reg)
            ST_STARTUP: begin
               off_cnt_reg <= '0;
               if (running_reg) begin
                  state_reg <= ST_ON;
               end
            end
            ST_ON: begin
               off_cnt_reg <= '0;
               if (cmp.cs_trip) begin
                  state_reg <= ST_RING;
               end
            end
            ST_RING: begin
               off_cnt_reg <= off_cnt_reg + 1'b1;
               if (off_cnt_reg == RING_END) begin
                  state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               off_cnt_reg <= off_cnt_reg + 1'b1;
               if (turn_on) begin
                  state_reg <= ST_ON;
                  off_cnt_reg <= '0;
               end
            end
            default: begin
               state_reg <= ST_STARTUP;
               off_cnt_reg <= '0;
            end
         endcase
      end
   end
   assign gate_on = (state_reg == ST_ON);

   // assertions
   a_charger_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cmp.supply_above_on && !latched_off) |=> !startup_cell_en)
      else $error("charger on after supply crossed turn-on");
   a_udc_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
      udc_value >= UDC_MIN && udc_value <= UDC_MAX) else $error("udc out of range");
   a_udc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (running_reg && !eval_tick && $past(running_reg)) |=> $stable(udc_value))
      else $error("udc changed mid period");
   a_udc_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (eval_tick && seen_reset_reg && running_reg) |=> udc_value == UDC_RESET)
      else $error("udc not forced to one");
   a_udc_up: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (eval_tick && !seen_low_reg && !cmp.fb_above_low && !seen_high_reg
       && !cmp.fb_above_high && !seen_reset_reg && !cmp.fb_above_reset
       && udc_value < UDC_MAX)
      |=> udc_value == $past(udc_value) + 3'h1) else $error("udc no increment");
   a_udc_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (eval_tick && seen_high_reg && !seen_reset_reg && !cmp.fb_above_reset
       && udc_value > UDC_MIN)
      |=> udc_value == $past(udc_value) - 3'h1) else $error("udc no decrement");
   a_valley_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(gate_on) |=> valley_count == VC_RESET) else $error("valley not cleared");
   a_valley_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cross_fall && valley_count != VC_MAX && (state_reg == ST_RING || state_reg == ST_WAIT))
      |=> valley_count == $past(valley_count) + 3'h1) else $error("valley not counted");
   a_ring_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(gate_on) && !latched_off |-> !gate_on [*3]) else $error("turn on in ringing");
   a_valley_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_WAIT && valley_count >= udc_value && !latched_off) |=> gate_on)
      else $error("no turn on at target valley");
   a_offmax_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_WAIT && off_cnt_reg == OFFMAX_END && !latched_off) |=> gate_on)
      else $error("no turn on at maximum off time");
   a_ovp_blank: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (running_reg && !gate_on && cmp.valley_above_ovp && ovp_cnt_reg == OVP_END)
      |=> latched_off) else $error("overvoltage not latched");
   a_latch_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
      latched_off |=> latched_off && !gate_on) else $error("latch-off released");
   a_ss_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(ss_step_reg) |-> $past(ss_cnt_reg) == SS_END)
      else $error("soft start step early");
   a_ss_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ss_done_reg |-> cs_limit_step == CS_LIMIT_FULL) else $error("limit not full");

   c_soft_start_done: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(ss_done_reg));
   c_valley_turn_on: cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == ST_WAIT && valley_count >= udc_value && valley_count != VC_RESET);
   c_udc_max: cover property (@(posedge clk_sys) disable iff (!rst_n) udc_value == UDC_MAX);
   c_latch: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(latched_off));
   c_offmax_on: cover property (@(posedge clk_sys) disable iff (!rst_n)
      state_reg == ST_WAIT && off_cnt_reg == OFFMAX_END);
endmodule
`default_nettype wire

// ==== bench/vsdc_stage_model.sv ====
// Purpose: behavioural flyback stage seen from the switch-on control core
// Assumes: fixed on-time until the current sense trips; ringing period set by the bench
// Notes: the ringing never damps, so long half periods exercise the off-time limit
`timescale 1ns/1ps
`default_nettype none
module vsdc_stage_model
   import vsdc_pkg::*;
#(
   parameter int ON_CYC = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // gate request and bench controls
   input wire logic gate_on,
   input wire logic [3:0] ring_half,
   input wire logic ovp_req,
   // comparator levels
   output logic cs_trip,
   output logic valley_below_cross,
   output logic valley_above_ovp
);
   logic [7:0] t_reg;
   logic [3:0] ph_reg;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         t_reg <= 8'h00;
         cs_trip <= 1'b0;
      end else begin
         t_reg <= gate_on ? t_reg + 8'h01 : 8'h00;
         cs_trip <= gate_on && (t_reg >= 8'(ON_CYC));
      end
   end
   // pin is clamped below the crossing level while on, so the level is already low at turn-off
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ph_reg <= 4'h0;
         valley_below_cross <= 1'b1;
      end else if (gate_on) begin
         ph_reg <= 4'h0;
         valley_below_cross <= 1'b1;
      end else if (ph_reg >= ring_half - 4'h1) begin
         ph_reg <= 4'h0;
         valley_below_cross <= !valley_below_cross;
      end else begin
         ph_reg <= ph_reg + 4'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         valley_above_ovp <= 1'b0;
      end else begin
         valley_above_ovp <= ovp_req && !gate_on;
      end
   end
endmodule
`default_nettype wire

// ==== bench/valley_switching_digital_control_tb.sv ====
// Purpose: self-checking bench for the valley switching control core
// Assumes: shortened soft-start, evaluation and off-time counts
// Notes: feedback level changes mid-period, so each period sees two levels
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("Error %s expected %0d seen %0d", nm, e, g); \
   end \
end
module valley_switching_digital_control_tb
   import vsdc_pkg::*;
;
   localparam int SS_C = 20;
   localparam int EV_C = 50;
   localparam int OM_C = 100;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sup = 1'b0;
   logic line_hi = 1'b0;
   logic ovp_req = 1'b0;
   logic [1:0] lvl = 2'h0;
   logic [3:0] ring_half = 4'h4;
   logic cs_trip, vbc, ovp;
   vsdc_cmp_t cmp;
   logic startup_cell_en, fb_thresh_high_line, gate_on, latched_off;
   logic [2:0] cs_limit_step, udc_value, valley_count;
   int compares = 0, n_mismatch = 0, cyc = 0, off_cnt = 0, n_step = 0, t_step = 0;
   logic p_gate = 1'b0, seen_off = 1'b0;
   logic [2:0] p_valley = 3'h0, p_udc = 3'h1, p_cs = 3'h0, exp_udc = 3'h1;
   logic [1:0] l_new, l_old = 2'h0;
   logic [1:0] corner [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 2, 2, 2, 1, 3, 0};

   assign cmp = {lvl >= 2'h1, lvl >= 2'h2, lvl == 2'h3, vbc, ovp, cs_trip, sup};

   vsdc_core #(.SS_STEP_CYCLES(SS_C), .EVAL_CYCLES(EV_C), .OFFMAX_CYCLES(OM_C)) vsdc_core_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .cmp_async(cmp), .line_high_async(line_hi),
      .startup_cell_en(startup_cell_en), .cs_limit_step(cs_limit_step),
      .fb_thresh_high_line(fb_thresh_high_line), .gate_on(gate_on),
      .latched_off(latched_off), .udc_value(udc_value), .valley_count(valley_count));

   vsdc_stage_model vsdc_stage_model_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .gate_on(gate_on), .ring_half(ring_half),
      .ovp_req(ovp_req), .cs_trip(cs_trip), .valley_below_cross(vbc), .valley_above_ovp(ovp));

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   function automatic logic [2:0] udc_nxt(input logic [2:0] u, input logic [1:0] l);
      case (l)
         2'h3: return 3'h1;
         2'h2: return (u > 3'h1) ? u - 3'h1 : 3'h1;
         2'h1: return u;
         default: return (u < 3'h7) ? u + 3'h1 : 3'h7;
      endcase
   endfunction

   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // bounded waits, so a stuck gate shows up as failed checks rather than a hang
   task automatic wait_fall();
      for (int k = 0; k < 300 && gate_on !== 1'b1; k++) @(posedge clk_sys);
      for (int k = 0; k < 300 && gate_on !== 1'b0; k++) @(posedge clk_sys);
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         $display("timeout after %0d cycles", cyc);
         stop_test();
      end
      if (rst_n && !startup_cell_en) begin
         if (cs_limit_step !== p_cs) begin
            `CHK("limit step", p_cs + 3'h1, cs_limit_step)
            if (n_step > 0) `CHK("step length", SS_C, cyc - t_step)
            t_step = cyc;
            n_step++;
         end
         if (gate_on && !p_gate && seen_off) begin
            `CHK("ring wait", 1, off_cnt >= RING_CYC - 1)
            `CHK("turn on cause", 1, p_valley >= p_udc || off_cnt >= OM_C - 3)
         end
         if (!gate_on && !latched_off && off_cnt == OM_C + 3) `CHK("max off", 1, 0)
         if (p_gate && !gate_on) `CHK("off cause", 1, cs_trip)
         if (gate_on && p_gate) `CHK("valley clear", 0, valley_count)
         else if (valley_count !== p_valley) `CHK("valley step", p_valley + 3'h1, valley_count)
         if (p_gate && !gate_on) seen_off = 1'b1;
         off_cnt = gate_on ? 0 : off_cnt + 1;
      end
      p_gate = gate_on;
      p_valley = valley_count;
      p_udc = udc_value;
      p_cs = cs_limit_step;
   end

   initial begin
      void'($urandom(47));
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      `CHK("udc at reset", 1, udc_value)
      `CHK("charger at reset", 1, startup_cell_en)
      repeat (3) @(posedge clk_sys);
      sup <= 1'b1;
      repeat (5) @(posedge clk_sys);
      `CHK("charger", 0, startup_cell_en)
      repeat (EV_C / 2 - 3) @(posedge clk_sys);
      $display("test startup done");
      for (int i = 0; i < 34; i++) begin
         l_new = (i < 16) ? corner[i] : 2'($urandom_range(0, 3));
         lvl <= l_new;
         line_hi <= 1'($urandom_range(0, 1));
         ring_half <= 4'($urandom_range(2, 12));
         repeat (EV_C) @(posedge clk_sys);
         exp_udc = udc_nxt(exp_udc, (l_new > l_old) ? l_new : l_old);
         l_old = l_new;
         `CHK("udc", exp_udc, udc_value)
         `CHK("line select", line_hi, fb_thresh_high_line)
      end
      `CHK("step count", 4, n_step)
      `CHK("full limit", CS_LIMIT_FULL, cs_limit_step)
      $display("test evaluation done");
      // a glitch shorter than the blanking time must not latch
      wait_fall();
      ovp_req <= 1'b1;
      repeat (5) @(posedge clk_sys);
      ovp_req <= 1'b0;
      repeat (40) @(posedge clk_sys);
      `CHK("short overvoltage", 0, latched_off)
      wait_fall();
      ovp_req <= 1'b1;
      repeat (40) @(posedge clk_sys);
      `CHK("overvoltage latch", 1, latched_off)
      ovp_req <= 1'b0;
      repeat (200) @(posedge clk_sys);
      `CHK("latch holds", 1, latched_off)
      `CHK("gate stays off", 0, gate_on)
      $display("test overvoltage done");
      stop_test();
   end
endmodule
`default_nettype wire
